/* flash_ctrl_pkg.sv */
// Purpose: constants and types for the flash write/erase controller
// Assumes: 2KB main array (4 x 512 B) at 0F800h, 256 B info at 01000h
// Notes: overview of the block's duties follows
// ****************************************************************
// Overview of operation
// ****************************************************************
// Overview of operation
// - Accept requests from CPU and debug port
// - CPU writes single bytes or 16-bit words
// - Four 64-byte info segments, separately erasable
// - Main segments are 512 bytes each
// - Main area: mass erase or single segment
// - Info segments: single, or with main erase
// - Segment A locked after reset until unlocked
// - Segment A top eight bytes hold calibration
package flash_ctrl_pkg;
    // Address layout
    localparam logic [15:0] INFO_BASE = 16'h1000;
    localparam logic [15:0] INFO_TOP = 16'h10FF;
    localparam logic [15:0] MAIN_BASE = 16'hF800;
    localparam logic [15:0] CAL_LOW = 16'h10F8;
    localparam logic [15:0] CAL_HIGH = 16'h10FF;
    // Segment geometry
    localparam int INFO_SEG_BYTES = 64;
    localparam int MAIN_SEG_BYTES = 512;
    localparam int INFO_SEGS = 4;
    localparam int MAIN_SEGS = 4;
    // Memory word layout: 1024 main words then 128 info words
    localparam int MEM_WORDS = 1152;
    localparam int AW = 11;
    localparam logic [10:0] INFO_WORD_BASE = 11'h400;
    localparam logic [10:0] SEG_A_WORD_BASE = 11'h460;
    localparam logic [10:0] LAST_WORD = 11'h47F;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    // Reset value of the segment A lock
    localparam logic LOCK_A_RST = 1'b1;
    // Operation codes
    localparam logic [2:0] OP_WRITE_BYTE = 3'h0;
    localparam logic [2:0] OP_WRITE_WORD = 3'h1;
    localparam logic [2:0] OP_ERASE_SEG = 3'h2;
    localparam logic [2:0] OP_ERASE_MAIN = 3'h3;
    localparam logic [2:0] OP_ERASE_ALL = 3'h4;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_ERASE = 3'b100
    } seq_state_t;
endpackage

/* flash_array_mem.sv */
// Purpose: word-wide storage standing in for the flash cells
// Assumes: one address per clock; it is read every clock and written in the same clock when enabled
// Notes: read data comes out of a register
`timescale 1ns/100ps
`default_nettype none
module flash_array_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [1:0] be,
    input wire logic [10:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata_ff
);
    // ************************************
    // Storage
    // ************************************
    // Cell contents, erased state is all ones
    logic [15:0] cells [0:flash_ctrl_pkg::MEM_WORDS-1];

    // Byte-lane write and registered read
    always_ff @(posedge clk) begin
        if (we && be[0]) begin
            cells[addr][7:0] <= wdata[7:0];
        end
        if (we && be[1]) begin
            cells[addr][15:8] <= wdata[15:8];
        end
        rdata_ff <= cells[addr];
    end
endmodule
`default_nettype wire

/* flash_segment_write_erase_ctrl.sv */
// Purpose: program/erase sequencer with segment A protection
// Assumes: requests held until ack; CPU and debug share one array
// Notes: writes AND into cells, like real flash (only clears bits)
`timescale 1ns/100ps
`default_nettype none
module flash_segment_write_erase_ctrl (
    input wire logic clk,
    input wire logic nrst,
    // CPU request group
    input wire logic cpu_req,
    input wire logic [2:0] cpu_op,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic cpu_ack,
    // Debug port request group
    input wire logic dbg_req,
    input wire logic [2:0] dbg_op,
    input wire logic [15:0] dbg_addr,
    input wire logic [15:0] dbg_wdata,
    output logic dbg_ack,
    // Segment A lock control
    input wire logic unlock_seg_a,
    input wire logic lock_seg_a,
    output logic seg_a_locked,
    // Status
    output logic busy,
    output logic blocked_ff,
    // Read port
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data
);
    // ************************************
    // Declarations
    // ************************************
    flash_ctrl_pkg::seq_state_t state_ff, nxt_state;
    logic lock_a_ff, nxt_lock_a;     // Segment A protection
    logic src_dbg_ff, nxt_src_dbg;   // Owner of running op
    logic [10:0] ptr_ff, nxt_ptr;    // Word pointer
    logic [10:0] end_ff, nxt_end;    // Last word of erase
    logic [15:0] wdat_ff, nxt_wdat;  // Write data
    logic [1:0] be_ff, nxt_be;       // Byte lanes
    logic nxt_blocked;
    logic [2:0] op;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic take_dbg;
    logic [10:0] widx;
    logic mem_we;
    logic [10:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic in_seg_a;

    // ************************************
    // Address mapping
    // ************************************
    // Byte address to word index; out of range maps past the end
    function automatic logic [10:0] word_index(input logic [15:0] a);
        logic [10:0] r;
        r = 11'h7FF;
        if (a >= flash_ctrl_pkg::MAIN_BASE) begin
            r = {1'b0, a[10:1]};
        end else if (a >= flash_ctrl_pkg::INFO_BASE &&
                     a <= flash_ctrl_pkg::INFO_TOP) begin
            r = flash_ctrl_pkg::INFO_WORD_BASE + {4'h0, a[7:1]};
        end
        return r;
    endfunction

    // ************************************
    // Request arbitration
    // ************************************
    // Debug port wins ties so the programmer can always get in
    // two request sources
    always_comb begin
        take_dbg = dbg_req;
        op = take_dbg ? dbg_op : cpu_op;
        addr = take_dbg ? dbg_addr : cpu_addr;
        wdata = take_dbg ? dbg_wdata : cpu_wdata;
        widx = word_index(addr);
    end

    // ************************************
    // Sequencer
    // ************************************
    // Next state, pointer and lock
    always_comb begin
        nxt_state = state_ff;
        nxt_lock_a = lock_a_ff;
        nxt_src_dbg = src_dbg_ff;
        nxt_ptr = ptr_ff;
        nxt_end = end_ff;
        nxt_wdat = wdat_ff;
        nxt_be = be_ff;
        nxt_blocked = blocked_ff;
        cpu_ack = 1'b0;
        dbg_ack = 1'b0;
        if (lock_seg_a) begin
            nxt_lock_a = 1'b1;
        end else if (unlock_seg_a) begin
            nxt_lock_a = 1'b0;
        end
        case (state_ff)
            flash_ctrl_pkg::ST_IDLE: begin
                if (cpu_req || dbg_req) begin
                    nxt_src_dbg = take_dbg;
                    nxt_ptr = widx;
                    nxt_blocked = 1'b0;
                    // Erases clear both lanes; a byte write narrows it
                    nxt_be = 2'b11;
                    case (op)
                        flash_ctrl_pkg::OP_WRITE_BYTE: begin
                            nxt_be = addr[0] ? 2'b10 : 2'b01;
                            nxt_wdat = {wdata[7:0], wdata[7:0]};
                            nxt_state = flash_ctrl_pkg::ST_WRITE;
                        end
                        flash_ctrl_pkg::OP_WRITE_WORD: begin
                            nxt_be = 2'b11;
                            nxt_wdat = wdata;
                            nxt_state = flash_ctrl_pkg::ST_WRITE;
                        end
                        flash_ctrl_pkg::OP_ERASE_SEG: begin
                            if (widx >= flash_ctrl_pkg::INFO_WORD_BASE) begin
                                nxt_ptr = {widx[10:5], 5'h00};
                                nxt_end = {widx[10:5], 5'h1F};
                            end else begin
                                nxt_ptr = {widx[10:8], 8'h00};
                                nxt_end = {widx[10:8], 8'hFF};
                            end
                            nxt_state = flash_ctrl_pkg::ST_ERASE;
                        end
                        flash_ctrl_pkg::OP_ERASE_MAIN: begin
                            nxt_ptr = 11'h000;
                            nxt_end = flash_ctrl_pkg::INFO_WORD_BASE - 11'h001;
                            nxt_state = flash_ctrl_pkg::ST_ERASE;
                        end
                        flash_ctrl_pkg::OP_ERASE_ALL: begin
                            nxt_ptr = 11'h000;
                            nxt_end = flash_ctrl_pkg::LAST_WORD;
                            nxt_state = flash_ctrl_pkg::ST_ERASE;
                        end
                        default: begin
                            // Unknown op: acknowledge at once and set blocked_ff
                            nxt_blocked = 1'b1;
                            cpu_ack = ~take_dbg;
                            dbg_ack = take_dbg;
                        end
                    endcase
                end
            end
            flash_ctrl_pkg::ST_WRITE: begin
                // Single cycle program then acknowledge
                if (in_seg_a && lock_a_ff) begin
                    nxt_blocked = 1'b1;
                end
                cpu_ack = ~src_dbg_ff;
                dbg_ack = src_dbg_ff;
                nxt_state = flash_ctrl_pkg::ST_IDLE;
            end
            flash_ctrl_pkg::ST_ERASE: begin
                // One word per clock until the span ends
                if (in_seg_a && lock_a_ff) begin
                    nxt_blocked = 1'b1;
                end
                if (ptr_ff >= end_ff) begin
                    cpu_ack = ~src_dbg_ff;
                    dbg_ack = src_dbg_ff;
                    nxt_state = flash_ctrl_pkg::ST_IDLE;
                end else begin
                    nxt_ptr = ptr_ff + 11'h001;
                end
            end
            default: begin
                nxt_state = flash_ctrl_pkg::ST_IDLE;
            end
        endcase
    end

    // Register the sequencer state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= flash_ctrl_pkg::ST_IDLE;
            lock_a_ff <= flash_ctrl_pkg::LOCK_A_RST;
            src_dbg_ff <= 1'b0;
            ptr_ff <= 11'h000;
            end_ff <= 11'h000;
            wdat_ff <= 16'h0000;
            be_ff <= 2'b00;
            blocked_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            lock_a_ff <= nxt_lock_a;
            src_dbg_ff <= nxt_src_dbg;
            ptr_ff <= nxt_ptr;
            end_ff <= nxt_end;
            wdat_ff <= nxt_wdat;
            be_ff <= nxt_be;
            blocked_ff <= nxt_blocked;
        end
    end

    // ************************************
    // Array access
    // ************************************
    // Write path and read path share the one array port
    always_comb begin
        // calibration bytes live in the top words of A
        in_seg_a = (ptr_ff >= flash_ctrl_pkg::SEG_A_WORD_BASE) &&
                   (ptr_ff <= flash_ctrl_pkg::LAST_WORD);
        // locked segment A is never written
        mem_we = (state_ff != flash_ctrl_pkg::ST_IDLE) &&
                 (ptr_ff <= flash_ctrl_pkg::LAST_WORD) &&
                 !(in_seg_a && lock_a_ff);
        // A pending request fetches its target word for the merge
        if (state_ff == flash_ctrl_pkg::ST_IDLE && (cpu_req || dbg_req)) begin
            mem_addr = widx;
        end else if (state_ff == flash_ctrl_pkg::ST_IDLE) begin
            mem_addr = word_index(rd_addr);
        end else begin
            mem_addr = ptr_ff;
        end
        // Programming can only clear bits, so the old word is merged
        if (state_ff == flash_ctrl_pkg::ST_ERASE) begin
            mem_wdata = flash_ctrl_pkg::ERASED_WORD;
        end else begin
            mem_wdata = wdat_ff & mem_rdata;
        end
    end

    // The take edge loads the target word, so the write merge sees it;
    // rd_data therefore shows that word in the cycle after the take edge
    flash_array_mem u_mem (
        .clk(clk),
        .we(mem_we),
        .be(be_ff),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata_ff(mem_rdata)
    );

    // ************************************
    // Outputs
    // ************************************
    assign seg_a_locked = lock_a_ff;
    assign busy = (state_ff != flash_ctrl_pkg::ST_IDLE);
    assign rd_data = mem_rdata;
endmodule
`default_nettype wire

/* flash_seq_monitor.sv */
// Purpose: port checker for the flash write/erase sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_seq_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cpu_req,
    input wire logic [2:0] cpu_op,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_ack,
    input wire logic dbg_req,
    input wire logic [2:0] dbg_op,
    input wire logic [15:0] dbg_addr,
    input wire logic dbg_ack,
    input wire logic unlock_seg_a,
    input wire logic lock_seg_a,
    input wire logic seg_a_locked,
    input wire logic busy,
    input wire logic blocked_ff
);
    // Debug wins ties, so a CPU take needs debug quiet
    wire logic cpu_take = cpu_req && !busy && !dbg_req;
    wire logic dbg_take = dbg_req && !busy;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    reset_state_a: assert property (disable iff (1'b0)
        !nrst |=> seg_a_locked && !busy && !blocked_ff) else $error("bad reset state");
    lock_wins_a: assert property (lock_seg_a |=> seg_a_locked)
        else $error("lock not set");
    unlock_clears_a: assert property (
        unlock_seg_a && !lock_seg_a |=> !seg_a_locked) else $error("unlock lost");
    write_ack_a: assert property (cpu_take && cpu_op[2:1] == 2'h0
        |=> cpu_ack && busy) else $error("write ack late");
    info_erase_a: assert property (cpu_take && cpu_op ==
        flash_ctrl_pkg::OP_ERASE_SEG && cpu_addr[15:8] == 8'h10
        |=> !cpu_ack [*8] ##24 cpu_ack) else $error("info erase span");
    main_erase_a: assert property (dbg_take && dbg_op ==
        flash_ctrl_pkg::OP_ERASE_SEG && dbg_addr[15:11] == 5'h1F
        |-> ##256 dbg_ack) else $error("main erase span");
    seg_a_guard_a: assert property (cpu_take && seg_a_locked &&
        cpu_addr[15:6] == 10'h043 |-> ##[1:33] blocked_ff) else $error("no block");
    ack_pulse_a: assert property (cpu_ack |=> !cpu_ack && !busy)
        else $error("ack too long");
    dbg_first_a: assert property (dbg_take && cpu_req &&
        dbg_op == flash_ctrl_pkg::OP_WRITE_WORD |=> dbg_ack && !cpu_ack)
        else $error("tie lost");
    cover property (dbg_take && cpu_req);
    cover property (cpu_take && cpu_op == flash_ctrl_pkg::OP_ERASE_ALL);
    cover property (unlock_seg_a && lock_seg_a);
endmodule
bind flash_segment_write_erase_ctrl flash_seq_monitor mon (.clk, .nrst,
    .cpu_req, .cpu_op, .cpu_addr, .cpu_ack, .dbg_req, .dbg_op, .dbg_addr,
    .dbg_ack, .unlock_seg_a, .lock_seg_a, .seg_a_locked, .busy, .blocked_ff);
`default_nettype wire

/* flash_requester.sv */
// Purpose: model of a CPU or debug port issuing flash requests
// Assumes: request held until ack, dropped just after it
// Notes: released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module flash_requester (
    input wire logic clk,
    input wire logic ack,
    output logic req,
    output logic [2:0] op,
    output logic [15:0] addr,
    output logic [15:0] wdata
);
    initial begin
        req = 1'b0;
        op = 3'h0;
        addr = 16'h0;
        wdata = 16'h0;
    end
    task automatic issue(input logic [2:0] o, input logic [15:0] a,
        input logic [15:0] d, output int n);
        n = 0;
        op = o;
        addr = a;
        wdata = d;
        req = 1'b1;
        // Bounded wait, so a lost ack cannot hang the model
        do begin
            @(negedge clk);
            n++;
        end while (ack !== 1'b1 && n < 1300);
        @(posedge clk);
        #5;
        req = 1'b0;
        op = ~o;
        addr = ~a;
        wdata = ~d;
        n = n - 1;
        // One edge passes before the next request
        @(posedge clk);
        #5;
    endtask
endmodule
`default_nettype wire

/* flash_segment_write_erase_ctrl_bench.sv */
// Purpose: self-checking bench for the flash sequencer
// Assumes: cells start unknown, so untouched cells never read FFFF
// Notes: inputs change 5 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("mismatch at %0t: got %0h want %0h", $time, g, e); end end
module flash_segment_write_erase_ctrl_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic unlock = 1'b0;
    logic lock = 1'b0;
    logic [15:0] rd_addr = 16'h0;
    wire logic cpu_req, dbg_req, cpu_ack, dbg_ack, locked, busy, blocked;
    wire logic [2:0] cpu_op, dbg_op;
    wire logic [15:0] cpu_addr, dbg_addr, cpu_wdata, dbg_wdata, rd_data;
    int fails = 0;
    int comparisons = 0;
    int n;
    int m;
    always #25 clk = ~clk;
    flash_segment_write_erase_ctrl DUT (.clk, .nrst, .cpu_req, .cpu_op,
        .cpu_addr, .cpu_wdata, .cpu_ack, .dbg_req, .dbg_op, .dbg_addr,
        .dbg_wdata, .dbg_ack, .unlock_seg_a(unlock), .lock_seg_a(lock),
        .seg_a_locked(locked), .busy, .blocked_ff(blocked), .rd_addr,
        .rd_data);
    flash_requester cpu_p (.clk, .ack(cpu_ack), .req(cpu_req), .op(cpu_op),
        .addr(cpu_addr), .wdata(cpu_wdata));
    flash_requester dbg_p (.clk, .ack(dbg_ack), .req(dbg_req), .op(dbg_op),
        .addr(dbg_addr), .wdata(dbg_wdata));
    // Read port has one cycle of latency; two edges leave margin
    task automatic rd(input logic [15:0] a);
        rd_addr = a;
        repeat (2) @(posedge clk);
        #5;
    endtask
    task automatic pulse(input logic u, input logic l);
        unlock = u;
        lock = l;
        @(posedge clk);
        #5;
        unlock = 1'b0;
        lock = 1'b0;
        @(posedge clk);
        #5;
    endtask
    task automatic close_out;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_writes;
        `CHK(locked, 1'b1)
        cpu_p.issue(flash_ctrl_pkg::OP_WRITE_BYTE, 16'hF801, 16'h00A5, n);
        `CHK(n, 1)
        cpu_p.issue(flash_ctrl_pkg::OP_WRITE_WORD, 16'hFFFE, 16'h1234, n);
        `CHK(n, 1)
        fork
            cpu_p.issue(flash_ctrl_pkg::OP_WRITE_WORD, 16'hF810, 16'h1, n);
            dbg_p.issue(flash_ctrl_pkg::OP_WRITE_WORD, 16'hF812, 16'h2, m);
        join
        `CHK(m, 1)
        `CHK(n > 1, 1'b1)
        cpu_p.issue(3'h7, 16'hF800, 16'h0, n);
        `CHK(n, 0)
        `CHK(blocked, 1'b1)
        $display("test writes done");
    endtask
    task automatic t_segments;
        dbg_p.issue(flash_ctrl_pkg::OP_ERASE_SEG, 16'hF800, 16'h0, n);
        `CHK(n, 256)
        rd(16'hF9FE);
        `CHK(rd_data, 16'hFFFF)
        rd(16'hFA00);
        `CHK(rd_data === 16'hFFFF, 1'b0)
        cpu_p.issue(flash_ctrl_pkg::OP_ERASE_SEG, 16'h1040, 16'h0, n);
        `CHK(n, 32)
        rd(16'h107E);
        `CHK(rd_data, 16'hFFFF)
        rd(16'h1080);
        `CHK(rd_data === 16'hFFFF, 1'b0)
        cpu_p.issue(flash_ctrl_pkg::OP_ERASE_SEG, 16'h10C0, 16'h0, n);
        `CHK(blocked, 1'b1)
        rd(16'h10F8);
        `CHK(rd_data === 16'hFFFF, 1'b0)
        cpu_p.issue(flash_ctrl_pkg::OP_WRITE_BYTE, 16'h10FF, 16'h0, n);
        `CHK(blocked, 1'b1)
        $display("test segments done");
    endtask
    task automatic t_mass;
        cpu_p.issue(flash_ctrl_pkg::OP_ERASE_MAIN, 16'hF800, 16'h0, n);
        `CHK(n, 1024)
        rd(16'hFFFE);
        `CHK(rd_data, 16'hFFFF)
        rd(16'h1000);
        `CHK(rd_data === 16'hFFFF, 1'b0)
        cpu_p.issue(flash_ctrl_pkg::OP_ERASE_ALL, 16'hF800, 16'h0, n);
        `CHK(n, 1152)
        rd(16'h1000);
        `CHK(rd_data, 16'hFFFF)
        rd(16'h10FE);
        `CHK(rd_data === 16'hFFFF, 1'b0)
        cpu_p.issue(flash_ctrl_pkg::OP_WRITE_WORD, 16'hFFFE, 16'h1234, n);
        rd(16'hFFFE);
        `CHK(rd_data, 16'h1234)
        cpu_p.issue(flash_ctrl_pkg::OP_WRITE_BYTE, 16'hF801, 16'h00A5, n);
        rd(16'hF800);
        `CHK(rd_data, 16'hA5FF)
        $display("test mass done");
    endtask
    task automatic t_unlock;
        pulse(1'b1, 1'b0);
        `CHK(locked, 1'b0)
        cpu_p.issue(flash_ctrl_pkg::OP_ERASE_SEG, 16'h10C0, 16'h0, n);
        `CHK(blocked, 1'b0)
        rd(16'h10FF);
        `CHK(rd_data, 16'hFFFF)
        pulse(1'b1, 1'b1);
        `CHK(locked, 1'b1)
        cpu_p.issue(flash_ctrl_pkg::OP_WRITE_BYTE, 16'h10FF, 16'h0, n);
        `CHK(blocked, 1'b1)
        rd(16'h10FE);
        `CHK(rd_data, 16'hFFFF)
        $display("test unlock done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #5;
        nrst = 1'b1;
        t_writes();
        t_segments();
        t_mass();
        t_unlock();
        close_out();
    end
    // Whole run is about 2600 cycles; allow ample margin
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
`default_nettype wire
